// [hdl/iera_pkg.sv]
// Constants, encodings and carriers for the indirect extended register access block
// Assumes a 10 MHz system clock and an upstream serial management frame decoder
package iera_pkg;

  // ------------------------------------------------------------
  // Management register addresses
  // ------------------------------------------------------------
  localparam logic [4:0]  IERA_CTRL_ADDR   = 5'h0D;
  localparam logic [4:0]  IERA_WIN_ADDR    = 5'h0E;
  localparam logic [4:0]  IERA_STAT_ADDR   = 5'h0C;
  localparam logic [4:0]  IERA_DEV_EXT     = 5'h1F;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int          IERA_FUNC_HI     = 15;
  localparam int          IERA_FUNC_LO     = 14;
  localparam int          IERA_DEV_HI      = 4;
  localparam int          IERA_DEV_LO      = 0;
  localparam int          IERA_STAT_LO     = 4;
  localparam int          IERA_STAT_W      = 5;
  localparam logic [15:0] IERA_PTR_RST     = 16'h0000;
  localparam logic [4:0]  IERA_DEV_RST     = 5'h00;
  localparam logic [4:0]  IERA_STAT_RST    = 5'h00;

  // ------------------------------------------------------------
  // Status bit order, criterion index
  // ------------------------------------------------------------
  localparam int          IERA_C_ENERGY    = 0;
  localparam int          IERA_C_SNR       = 1;
  localparam int          IERA_C_CODE      = 2;
  localparam int          IERA_C_RXERR     = 3;
  localparam int          IERA_C_DESCR     = 4;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          IERA_CLK_MHZ     = 10;
  localparam int          IERA_WIN_NS      = 10000;
  localparam int          IERA_WIN_CYC     = IERA_CLK_MHZ * IERA_WIN_NS / 1000;
  localparam int          IERA_RXERR_LIM   = 32;
  localparam int          IERA_CODE_LIM    = 20;
  localparam int          IERA_SNR_LIM     = 20;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    IERA_FN_ADDR   = 2'h0,
    IERA_FN_DATA   = 2'h1,
    IERA_FN_INC_RW = 2'h2,
    IERA_FN_INC_WR = 2'h3
  } iera_func_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } iera_mgmt_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } iera_ext_req_t;

endpackage

// [hdl/iera_top.sv]
// Indirect extended register access and link drop cause status
// Assumes decoded management accesses, one cycle strobes, and a combinational extended register file
//
// Overview of operation
// RQ1: Extended space reached only through control/window pair
// RQ2: Function 00: window write loads the pointer
// RQ3: Host loads pointer before any data access
// RQ4: Function 01: access pointed register, pointer kept
// RQ5: Function 10: increment pointer after each access
// RQ6: Function 11: increment after writes, not reads
// RQ7: Window transactions accepted only with device code 11111
// RQ8: Host writes 0x1F into device code first
// RQ9: Control bits 13:5 ignore writes, read zero
// RQ10: Window reads pointer in 00, data otherwise
// RQ11: Status bit latches when enabled criterion drops link
// RQ12: Status bits 8:4 in fixed criterion order
// RQ13: Function, device code, window reset to zero
// RQ14: Link drop is OR of enabled criteria
// RQ15: Receive error criterion: 32 within 10 us
// RQ16: Line code criterion: 20 within 10 us
// RQ17: Status bit held until read, read clears it
// RQ18: Pointer wraps from FFFF to zero
`timescale 1ns/100ps
module iera_top
  import iera_pkg::*;
#(
  parameter int RXERR_LIMIT = IERA_RXERR_LIM,
  parameter int CODE_LIMIT  = IERA_CODE_LIM,
  parameter int SNR_LIMIT   = IERA_SNR_LIM,
  parameter int WIN_CYCLES  = IERA_WIN_CYC
) (
  input  wire logic           SYS_CLK_I,
  input  wire logic           NRST_I,
  input  wire iera_mgmt_req_t MGMT_REQ_I,
  output logic [15:0]         MGMT_RDATA_O,
  output iera_ext_req_t       EXT_REQ_O,
  input  wire logic [15:0]    EXT_RDATA_I,
  input  wire logic [4:0]     DROP_EN_I,
  input  wire logic           RX_ERR_I,
  input  wire logic           CODE_ERR_I,
  input  wire logic           SNR_LOW_I,
  input  wire logic           ENERGY_LOSS_I,
  input  wire logic           DESCR_LOSS_I,
  output logic                LINK_DROP_O
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (RXERR_LIMIT < 1 || RXERR_LIMIT > 63) begin : g_bad_rxerr
    $error("iera_top: receive error limit must lie in 1 to 63");
  end

  if (CODE_LIMIT < 1 || CODE_LIMIT > 63) begin : g_bad_code
    $error("iera_top: line code limit must lie in 1 to 63");
  end

  if (SNR_LIMIT < 1 || SNR_LIMIT > 63) begin : g_bad_snr
    $error("iera_top: low signal limit must lie in 1 to 63");
  end

  if (WIN_CYCLES < 2 || WIN_CYCLES > 65535) begin : g_bad_win
    $error("iera_top: window length must lie in 2 to 65535");
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int WW = $clog2(WIN_CYCLES);

  iera_func_t  func_r;
  logic [4:0]  dev_r;
  logic [15:0] ptr_r;
  logic [15:0] ptr_nxt;
  logic [15:0] rdata_nxt;
  logic [15:0] ctrl_val;
  logic [15:0] win_val;
  logic [15:0] stat_val;
  logic        ptr_load;
  logic        ptr_inc;
  logic        any_hit;
  logic [4:0]  stat_r;
  logic [4:0]  stat_nxt;
  logic        drop_r;
  logic [WW-1:0] win_cnt_r;
  logic        win_end;
  logic        dev_ok;
  logic        win_wr;
  logic        win_rd;
  logic        data_acc;
  logic        ctrl_wr;
  logic        stat_rd;
  logic [4:0]  hit;
  logic [2:0]  cnt_evt;
  logic [2:0]  cnt_fire;
  logic [5:0]  cnt_lim [3];

  assign cnt_lim[0] = 6'(SNR_LIMIT);
  assign cnt_lim[1] = 6'(CODE_LIMIT);
  assign cnt_lim[2] = 6'(RXERR_LIMIT);

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  assign dev_ok   = (dev_r == IERA_DEV_EXT);                                   // see RQ7
  assign win_wr   = MGMT_REQ_I.wr && (MGMT_REQ_I.addr == IERA_WIN_ADDR) && dev_ok;
  assign win_rd   = MGMT_REQ_I.rd && (MGMT_REQ_I.addr == IERA_WIN_ADDR) && dev_ok;
  assign data_acc = (win_wr || win_rd) && (func_r != IERA_FN_ADDR);
  assign ctrl_wr  = MGMT_REQ_I.wr && (MGMT_REQ_I.addr == IERA_CTRL_ADDR);
  assign stat_rd  = MGMT_REQ_I.rd && (MGMT_REQ_I.addr == IERA_STAT_ADDR);

  // ------------------------------------------------------------
  // Extended register port
  // ------------------------------------------------------------
  assign EXT_REQ_O.addr  = ptr_r;                                              // see RQ1
  assign EXT_REQ_O.wr    = data_acc && MGMT_REQ_I.wr;                          // see RQ4
  assign EXT_REQ_O.rd    = data_acc && MGMT_REQ_I.rd;
  assign EXT_REQ_O.wdata = MGMT_REQ_I.wdata;

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      func_r <= IERA_FN_ADDR;                                                  // see RQ13
    end else if (ctrl_wr) begin
      func_r <= iera_func_t'(MGMT_REQ_I.wdata[IERA_FUNC_HI:IERA_FUNC_LO]);
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      dev_r <= IERA_DEV_RST;                                                   // see RQ13
    end else if (ctrl_wr) begin
      dev_r <= MGMT_REQ_I.wdata[IERA_DEV_HI:IERA_DEV_LO];                      // see RQ9
    end
  end

  // ------------------------------------------------------------
  // Extended space pointer
  // ------------------------------------------------------------
  assign ptr_load = win_wr && (func_r == IERA_FN_ADDR);                        // see RQ2
  assign ptr_inc  = data_acc && (func_r == IERA_FN_INC_RW ||                   // see RQ5
                                 (func_r == IERA_FN_INC_WR && MGMT_REQ_I.wr)); // see RQ6

  always_comb begin
    ptr_nxt = ptr_r;
    if (ptr_load) begin
      ptr_nxt = MGMT_REQ_I.wdata;
    end else if (ptr_inc) begin
      ptr_nxt = ptr_r + 16'h0001;                                              // see RQ18
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ptr_r <= IERA_PTR_RST;                                                   // see RQ13
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_comb begin
    ctrl_val = 16'h0000;                                                       // see RQ9
    ctrl_val[IERA_FUNC_HI:IERA_FUNC_LO] = func_r;
    ctrl_val[IERA_DEV_HI:IERA_DEV_LO]   = dev_r;
  end

  always_comb begin
    win_val = 16'h0000;                                                        // see RQ7
    if (dev_ok) begin
      win_val = (func_r == IERA_FN_ADDR) ? ptr_r : EXT_RDATA_I;                // see RQ10
    end
  end

  always_comb begin
    stat_val = 16'h0000;                                                       // see RQ12
    stat_val[IERA_STAT_LO +: IERA_STAT_W] = stat_r;
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (MGMT_REQ_I.addr)
      IERA_CTRL_ADDR: rdata_nxt = ctrl_val;
      IERA_WIN_ADDR:  rdata_nxt = win_val;
      IERA_STAT_ADDR: rdata_nxt = stat_val;
      default:        rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      MGMT_RDATA_O <= 16'h0000;
    end else if (MGMT_REQ_I.rd) begin
      MGMT_RDATA_O <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Counting window
  // ------------------------------------------------------------
  assign win_end = (win_cnt_r == WW'(WIN_CYCLES - 1));

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      win_cnt_r <= '0;
    end else if (win_end) begin
      win_cnt_r <= '0;
    end else begin
      win_cnt_r <= win_cnt_r + WW'(1);
    end
  end

  // ------------------------------------------------------------
  // Event counters, fire once per window on reaching the limit
  // ------------------------------------------------------------
  assign cnt_evt = {RX_ERR_I, CODE_ERR_I, SNR_LOW_I};

  for (genvar g = 0; g < 3; g++) begin : g_cnt
    logic [5:0] cnt_r;
    assign cnt_fire[g] = cnt_evt[g] && (cnt_r == cnt_lim[g] - 6'h01);           // see RQ15 RQ16
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        cnt_r <= 6'h00;
      end else if (win_end) begin
        cnt_r <= 6'h00;
      end else if (cnt_evt[g] && cnt_r < cnt_lim[g]) begin
        cnt_r <= cnt_r + 6'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Link drop and latched cause
  // ------------------------------------------------------------
  assign hit[IERA_C_ENERGY] = ENERGY_LOSS_I && DROP_EN_I[IERA_C_ENERGY];
  assign hit[IERA_C_SNR]    = cnt_fire[0] && DROP_EN_I[IERA_C_SNR];
  assign hit[IERA_C_CODE]   = cnt_fire[1] && DROP_EN_I[IERA_C_CODE];            // see RQ16
  assign hit[IERA_C_RXERR]  = cnt_fire[2] && DROP_EN_I[IERA_C_RXERR];           // see RQ15
  assign hit[IERA_C_DESCR]  = DESCR_LOSS_I && DROP_EN_I[IERA_C_DESCR];
  assign any_hit            = |hit;

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      drop_r <= 1'b0;
    end else begin
      drop_r <= any_hit;                                                       // see RQ14
    end
  end

  assign LINK_DROP_O = drop_r;

  always_comb begin
    stat_nxt = stat_r;
    if (stat_rd) begin
      stat_nxt = IERA_STAT_RST;                                                // see RQ17
    end
    stat_nxt = stat_nxt | hit;                                                 // see RQ11
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      stat_r <= IERA_STAT_RST;
    end else begin
      stat_r <= stat_nxt;
    end
  end

endmodule

// [tb/iera_ext_regfile.sv]
// Extended register file model behind the indirect window
// Combinational read from the pointer, write on the strobe edge
`timescale 1ns/100ps
module iera_ext_regfile
  import iera_pkg::*;
(
  input  wire logic          SYS_CLK_I,
  input  wire iera_ext_req_t REQ_I,
  output logic [15:0]        RDATA_O
);
  logic [15:0] mem_r [16];
  initial for (int i = 0; i < 16; i++) mem_r[i] = 16'hA000 + 16'(i);
  always @(posedge SYS_CLK_I) if (REQ_I.wr) mem_r[REQ_I.addr[3:0]] <= REQ_I.wdata;
  // Inverted data outside a read strobe
  assign RDATA_O = REQ_I.rd ? mem_r[REQ_I.addr[3:0]] : ~mem_r[REQ_I.addr[3:0]];
endmodule

// [tb/iera_assertions.sv]
// Checker for the indirect access block
// Bound to iera_top, sees only its ports
`timescale 1ns/100ps
module iera_assertions
  import iera_pkg::*;
(
  input wire logic           SYS_CLK_I,
  input wire logic           NRST_I,
  input wire iera_mgmt_req_t MGMT_REQ_I,
  input wire logic [15:0]    MGMT_RDATA_O,
  input wire iera_ext_req_t  EXT_REQ_O,
  input wire logic [15:0]    EXT_RDATA_I,
  input wire logic [4:0]     DROP_EN_I,
  input wire logic           ENERGY_LOSS_I,
  input wire logic           DESCR_LOSS_I,
  input wire logic           LINK_DROP_O
);
  logic [15:0] ctrl_r;
  logic [1:0]  fn;
  logic        ww;
  logic        wr_rd;
  logic        dev_ok;
  logic        lvl_drop;
  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) ctrl_r <= 16'h0000;
    else if (MGMT_REQ_I.wr && MGMT_REQ_I.addr == IERA_CTRL_ADDR) ctrl_r <= MGMT_REQ_I.wdata;
  end
  assign fn = ctrl_r[15:14];
  assign dev_ok = ctrl_r[4:0] == IERA_DEV_EXT;
  assign ww = MGMT_REQ_I.wr && MGMT_REQ_I.addr == IERA_WIN_ADDR && dev_ok;
  assign wr_rd = MGMT_REQ_I.rd && MGMT_REQ_I.addr == IERA_WIN_ADDR && dev_ok;
  assign lvl_drop = (DROP_EN_I[0] && ENERGY_LOSS_I) || (DROP_EN_I[4] && DESCR_LOSS_I);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence acc_s(logic [1:0] f);
    (ww || wr_rd) && fn == f;
  endsequence
  sequence reg_rd_s(logic [4:0] a);
    MGMT_REQ_I.rd && MGMT_REQ_I.addr == a;
  endsequence
  sequence win_bad_rd_s;
    MGMT_REQ_I.rd && MGMT_REQ_I.addr == IERA_WIN_ADDR && !dev_ok;
  endsequence
  ext_wr_gate_a: assert property (EXT_REQ_O.wr == (ww && fn != 2'h0)) else $error("ext write gate");
  ext_rd_gate_a: assert property (EXT_REQ_O.rd == (wr_rd && fn != 2'h0)) else $error("ext read gate");
  ptr_load_a: assert property (ww && fn == 2'h0 |=> EXT_REQ_O.addr == $past(MGMT_REQ_I.wdata))
    else $error("pointer not loaded");
  ptr_keep_a: assert property (acc_s(2'h1) |=> $stable(EXT_REQ_O.addr)) else $error("pointer moved");
  inc_both_a: assert property (acc_s(2'h2) |=> EXT_REQ_O.addr == $past(EXT_REQ_O.addr) + 16'h0001)
    else $error("no increment");
  inc_wr_a: assert property (ww && fn == 2'h3 |=> EXT_REQ_O.addr == $past(EXT_REQ_O.addr) + 16'h0001)
    else $error("no write increment");
  rd_keep_a: assert property (wr_rd && fn == 2'h3 |=> $stable(EXT_REQ_O.addr)) else $error("read moved");
  win_data_a: assert property (EXT_REQ_O.rd |=> MGMT_RDATA_O == $past(EXT_RDATA_I)) else $error("bad data");
  win_ptr_a: assert property (wr_rd && fn == 2'h0 |=> MGMT_RDATA_O == $past(EXT_REQ_O.addr))
    else $error("bad pointer read");
  bad_dev_a: assert property (win_bad_rd_s |=> MGMT_RDATA_O == 16'h0000)
    else $error("bad code read");
  drop_lvl_a: assert property (lvl_drop |=> LINK_DROP_O) else $error("no link drop");
  ctrl_rd_a: assert property (reg_rd_s(IERA_CTRL_ADDR) |=> MGMT_RDATA_O == ($past(ctrl_r) & 16'hC01F))
    else $error("bad control read");
  stat_rsvd_a: assert property (reg_rd_s(IERA_STAT_ADDR) |=> (MGMT_RDATA_O & 16'hFE0F) == 16'h0000)
    else $error("status reserved bits set");
endmodule
bind iera_top iera_assertions u_iera_assertions (.SYS_CLK_I, .NRST_I, .MGMT_REQ_I, .MGMT_RDATA_O, .EXT_REQ_O,
  .EXT_RDATA_I, .DROP_EN_I, .ENERGY_LOSS_I, .DESCR_LOSS_I, .LINK_DROP_O);

// [tb/iera_tb_top.sv]
// Testbench for the indirect access block
// Drives decoded management requests, models the extended file
`timescale 1ns/100ps
module iera_tb_top
  import iera_pkg::*;
;
  logic           clk;
  logic           nrst;
  iera_mgmt_req_t req;
  logic [15:0]    rdata;
  iera_ext_req_t  ext;
  logic [15:0]    ext_rdata;
  logic [4:0]     drop_en;
  logic [4:0]     ev;
  logic           drop;
  int             err_count;
  int             samples_checked;
  iera_top #(.RXERR_LIMIT(4), .CODE_LIMIT(4), .SNR_LIMIT(4)) u_iera_top (.SYS_CLK_I(clk), .NRST_I(nrst),
    .MGMT_REQ_I(req), .MGMT_RDATA_O(rdata), .EXT_REQ_O(ext), .EXT_RDATA_I(ext_rdata), .DROP_EN_I(drop_en),
    .RX_ERR_I(ev[3]), .CODE_ERR_I(ev[2]), .SNR_LOW_I(ev[1]), .ENERGY_LOSS_I(ev[0]), .DESCR_LOSS_I(ev[4]),
    .LINK_DROP_O(drop));
  iera_ext_regfile u_iera_ext_regfile (.SYS_CLK_I(clk), .REQ_I(ext), .RDATA_O(ext_rdata));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic mwr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{a, 1'b1, 1'b0, d};
    @(posedge clk) req <= '{a, 1'b0, 1'b0, d};
  endtask
  task automatic mrd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk) req <= '{a, 1'b0, 1'b1, 16'h0000};
    @(posedge clk) req <= '{a, 1'b0, 1'b0, 16'h0000};
    @(negedge clk) chk(rdata, e);
  endtask
  task automatic t_reset();
    mrd(IERA_CTRL_ADDR, 16'h0000);
    mrd(IERA_WIN_ADDR, 16'h0000);
    mrd(IERA_STAT_ADDR, 16'h0000);
    mwr(IERA_CTRL_ADDR, 16'hFFFF);
    mrd(IERA_CTRL_ADDR, 16'hC01F);
    mrd(5'h01, 16'h0000);
  endtask
  task automatic t_modes();
    mwr(IERA_CTRL_ADDR, 16'h001F);
    mwr(IERA_WIN_ADDR, 16'h0004);
    mrd(IERA_WIN_ADDR, 16'h0004);
    mwr(IERA_CTRL_ADDR, 16'h401F);
    mwr(IERA_WIN_ADDR, 16'h1111);
    mrd(IERA_WIN_ADDR, 16'h1111);
    mwr(IERA_CTRL_ADDR, 16'h801F);
    mwr(IERA_WIN_ADDR, 16'h2222);
    mrd(IERA_WIN_ADDR, 16'hA005);
    mwr(IERA_CTRL_ADDR, 16'hC01F);
    mwr(IERA_WIN_ADDR, 16'h3333);
    mrd(IERA_WIN_ADDR, 16'hA007);
    mrd(IERA_WIN_ADDR, 16'hA007);
    mwr(IERA_CTRL_ADDR, 16'h001F);
    mrd(IERA_WIN_ADDR, 16'h0007);
    mwr(IERA_WIN_ADDR, 16'hFFFF);
    mwr(IERA_CTRL_ADDR, 16'h801F);
    mrd(IERA_WIN_ADDR, 16'hA00F);
    mwr(IERA_CTRL_ADDR, 16'h001F);
    mrd(IERA_WIN_ADDR, 16'h0000);
  endtask
  task automatic t_bad_dev();
    mwr(IERA_CTRL_ADDR, 16'h401E);
    mwr(IERA_WIN_ADDR, 16'h5555);
    mrd(IERA_WIN_ADDR, 16'h0000);
    mwr(IERA_CTRL_ADDR, 16'h401F);
    mrd(IERA_WIN_ADDR, 16'hA000);
  endtask
  task automatic t_drop();
    int n;
    int f;
    for (int i = 0; i < 6; i++) begin
      n = 0;
      f = -1;
      @(posedge clk) drop_en <= (i < 5) ? 5'(1 << i) : 5'h00;
      for (int k = 0; k < 20; k++) begin
        @(posedge clk) ev <= (i < 5) ? 5'(1 << i) : 5'h1F;
        @(negedge clk) if (drop === 1'b1) begin
          n++;
          if (f < 0) f = k;
        end
      end
      @(posedge clk) ev <= 5'h00;
      chk(16'(n != 0), 16'(i < 5));
      if (i == 0 || i == 4) chk(16'(n), 16'h0013);
      if (i > 0 && i < 4) chk(16'(f >= 4 && n <= 2), 16'h0001);
      mrd(IERA_STAT_ADDR, (i < 5) ? 16'(1 << (i + 4)) : 16'h0000);
      mrd(IERA_STAT_ADDR, 16'h0000);
    end
  endtask
  task automatic t_recur();
    @(posedge clk) drop_en <= 5'h01;
    ev <= 5'h01;
    @(posedge clk) req <= '{IERA_STAT_ADDR, 1'b0, 1'b1, 16'h0000};
    @(posedge clk) begin
      req <= '{IERA_STAT_ADDR, 1'b0, 1'b0, 16'h0000};
      ev <= 5'h00;
    end
    @(negedge clk) chk(rdata, 16'h0010);
    mrd(IERA_STAT_ADDR, 16'h0010);
    mrd(IERA_STAT_ADDR, 16'h0000);
  endtask
  task automatic t_midreset();
    mwr(IERA_CTRL_ADDR, 16'h001F);
    mwr(IERA_WIN_ADDR, 16'h1234);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    mrd(IERA_CTRL_ADDR, 16'h0000);
    mwr(IERA_CTRL_ADDR, 16'h001F);
    mrd(IERA_WIN_ADDR, 16'h0000);
  endtask
  task automatic print_verdict();
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end
  initial begin
    nrst = 1'b0;
    req = '0;
    drop_en = 5'h00;
    ev = 5'h00;
    err_count = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_modes();
    t_bad_dev();
    t_drop();
    t_recur();
    t_midreset();
    print_verdict();
  end
endmodule
